// [dv/cpm_core_sva.sv]
// Purpose: Port-level checks of the core model
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every cpm_core instance
`timescale 1ns/1ps
`default_nettype none
module cpm_core_sva
  import cpm_pkg::*;
(
  input wire logic              clk_sys,
  input wire logic              rst,
  input wire logic              step,
  input wire logic              jump,
  input wire logic [INSN_W-1:0] prog_rdata,
  input wire logic [INSN_W-1:0] insn_word,
  input wire logic              dreq,
  input wire logic              dwrite,
  input wire logic              dual_mac,
  input wire logic              page_we,
  input wire logic [PAGE_W-1:0] page_wdata,
  input wire logic              dvalid,
  input wire logic              y_active,
  input wire logic [PAGE_W-1:0] program_window_page,
  input wire logic [TRAP_N-1:0] trap_req,
  input wire logic              exc_take,
  input wire logic [5:0]        exc_vector,
  input wire logic [PRI_W-1:0]  exc_level,
  input wire logic [15:0]       stack_pointer_reg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  sequence s_trap_in;
    |trap_req;
  endsequence
  sequence s_trap_out;
    exc_take && exc_vector < 6'h08 && exc_level >= TRAP_PRI_MIN;
  endsequence
  a_sp_bit_zero: assert property (!stack_pointer_reg[0])
    else $error("stack pointer bit 0 set");
  a_sp_reset_val: assert property ($past(rst) |->
    stack_pointer_reg == SP_RESET) else $error("stack pointer reset value");
  a_trap_outranks: assert property (s_trap_in |=> s_trap_out)
    else $error("trap not taken above interrupts");
  a_trap_top: assert property (trap_req[0] |=>
    exc_vector == 6'h00 && exc_level == 4'hF) else $error("trap 0 level");
  a_irq_level_range: assert property (exc_take && exc_vector >= 6'h08
    |-> exc_level >= 4'h1 && exc_level <= 4'h7)
    else $error("interrupt level out of range");
  a_vector_range: assert property (exc_take |-> exc_vector < 6'd62)
    else $error("vector out of range");
  a_read_answer: assert property (dreq && !dwrite |-> ##[1:2] dvalid)
    else $error("data read not answered");
  a_page_load: assert property (page_we |=>
    program_window_page == $past(page_wdata)) else $error("page load");
  a_x_only_access: assert property (dreq && !dual_mac |=> !y_active)
    else $error("Y generator used without dual access");
  a_fetch_word: assert property (step && !jump |=>
    insn_word == $past(prog_rdata)) else $error("fetched word");
endmodule
`default_nettype wire
bind cpm_core cpm_core_sva u_sva (.clk_sys(clk_sys), .rst(rst),
  .step(step), .jump(jump), .prog_rdata(prog_rdata),
  .insn_word(insn_word), .dreq(dreq), .dwrite(dwrite),
  .dual_mac(dual_mac), .page_we(page_we), .page_wdata(page_wdata),
  .dvalid(dvalid), .y_active(y_active),
  .program_window_page(program_window_page), .trap_req(trap_req),
  .exc_take(exc_take), .exc_vector(exc_vector), .exc_level(exc_level),
  .stack_pointer_reg(stack_pointer_reg));

// [dv/cpm_core_tb_top.sv]
// Purpose: Self-checking bench for the core model
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Data memory contents are not modelled, only answer timing
`timescale 1ns/1ps
`default_nettype none
module cpm_core_tb_top;
  import cpm_pkg::*;
  logic clk_sys, rst, step, jump, loop_start, loop_end, shadow_save;
  logic shadow_restore, prog_rd, dreq, dwrite, dbyte, dual_mac, bitrev;
  logic modulo_en, page_we, tbl_req, y_active, dvalid, mac_go, acc_sel;
  logic shift_left, exc_take;
  logic [PC_W-1:0] jump_target, loop_begin_in, loop_finish_in, prog_addr;
  logic [13:0] loop_count_in;
  logic [INSN_W-1:0] prog_rdata, insn_word, tbl_rdata;
  logic [15:0] mod_start, mod_end, dwdata, x_addr, y_addr, drdata;
  logic [15:0] status_word, stack_pointer_reg, sp_exp;
  logic [3:0] addr_reg, exc_level;
  logic [7:0] page_wdata, tbl_page, program_window_page, trap_req;
  logic [4:0] shift_amt;
  logic [ACC_W-1:0] acc1, acc2;
  logic [IRQ_N-1:0] irq_req;
  logic [IRQ_N*3-1:0] irq_pri;
  logic [5:0] exc_vector;
  int miscompares, total_checks, i;
  cpm_core u_cpm_core (.clk_sys(clk_sys), .rst(rst), .step(step),
    .jump(jump), .jump_target(jump_target), .loop_start(loop_start),
    .loop_end(loop_end), .loop_begin_in(loop_begin_in),
    .loop_finish_in(loop_finish_in), .loop_count_in(loop_count_in),
    .shadow_save(shadow_save), .shadow_restore(shadow_restore),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata),
    .insn_word(insn_word), .dreq(dreq), .dwrite(dwrite), .dbyte(dbyte),
    .dual_mac(dual_mac), .bitrev(bitrev), .modulo_en(modulo_en),
    .mod_start(mod_start), .mod_end(mod_end), .addr_reg(addr_reg),
    .dwdata(dwdata), .page_we(page_we), .page_wdata(page_wdata),
    .tbl_req(tbl_req), .tbl_page(tbl_page), .x_addr(x_addr),
    .y_addr(y_addr), .y_active(y_active), .dvalid(dvalid),
    .drdata(drdata), .tbl_rdata(tbl_rdata),
    .program_window_page(program_window_page), .mac_go(mac_go),
    .acc_sel(acc_sel), .shift_amt(shift_amt), .shift_left(shift_left),
    .accumulator_one(acc1), .accumulator_two(acc2), .trap_req(trap_req),
    .irq_req(irq_req), .irq_pri(irq_pri), .exc_take(exc_take),
    .exc_vector(exc_vector), .exc_level(exc_level),
    .status_word(status_word), .stack_pointer_reg(stack_pointer_reg));
  cpm_prog_mem_model u_cpm_prog_mem_model (.clk_sys(clk_sys),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_rdata(prog_rdata));
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string name, input logic [39:0] seen,
                     input logic [39:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Raise a trap mask and up to two interrupt requests for one cycle and check the answer
  task automatic exc(input logic [7:0] t, input int n0, input int n1,
                     input logic [2:0] p0, input logic [2:0] p1,
                     input logic [5:0] vec, input logic [3:0] lvl);
    trap_req = t;
    irq_req = '0;
    irq_pri = '0;
    if (n0 >= 0) begin irq_req[n0] = 1'b1; irq_pri[n0*3 +: 3] = p0; end
    if (n1 >= 0) begin irq_req[n1] = 1'b1; irq_pri[n1*3 +: 3] = p1; end
    tick();
    trap_req = '0;
    irq_req = '0;
    chk("exc_take", exc_take, 1'b1);
    chk("exc_vector", exc_vector, vec);
    chk("exc_level", exc_level, lvl);
    tick();
    sp_exp = sp_exp + 16'h0004;
    chk("stack_pointer_reg", stack_pointer_reg, sp_exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    miscompares = 0;
    total_checks = 0;
    {step, jump, loop_start, loop_end, shadow_save, shadow_restore} = '0;
    {dreq, dwrite, dbyte, dual_mac, bitrev, modulo_en, page_we} = '0;
    {tbl_req, mac_go, acc_sel, shift_left, shift_amt} = '0;
    {jump_target, loop_begin_in, loop_finish_in, loop_count_in} = '0;
    {mod_start, mod_end, dwdata, addr_reg, page_wdata, tbl_page} = '0;
    trap_req = '0;
    irq_req = '0;
    irq_pri = '0;
    rst = 1'b1;
    repeat (6) tick();
    rst = 1'b0;
    sp_exp = SP_RESET;
    chk("stack_pointer_reg", stack_pointer_reg, 16'h0800);
    chk("program_window_page", program_window_page, 8'h00);
    page_we = 1'b1;
    page_wdata = 8'hA5;
    tick();
    page_we = 1'b0;
    chk("program_window_page", program_window_page, 8'hA5);
    step = 1'b1;
    tick();
    chk("insn_word", insn_word, 24'h5A0000);
    jump = 1'b1;
    jump_target = 23'h400003;
    tick();
    {step, jump} = '0;
    chk("prog_addr", prog_addr, 23'h000002);
    // Read with addr_reg at the stack pointer; the registered read still yields W0 (0x0000), below the program window
    dreq = 1'b1;
    addr_reg = SP_IDX;
    tick();
    dreq = 1'b0;
    chk("dvalid", dvalid, 1'b1);
    chk("y_active", y_active, 1'b0);
    tick();
    // Write W1, then use it as an address inside the program window
    dreq = 1'b1;
    dwrite = 1'b1;
    addr_reg = 4'h1;
    dwdata = 16'h9234;
    tick();
    dreq = 1'b0;
    dwrite = 1'b0;
    tick();
    dreq = 1'b1;
    tick();
    dreq = 1'b0;
    chk("prog_addr", prog_addr, {8'hA5, 15'h1234});
    chk("x_addr", x_addr, 16'h9234);
    chk("dvalid", dvalid, 1'b0);
    dual_mac = 1'b1;
    bitrev = 1'b1;
    dwrite = 1'b1;
    tick();
    chk("dvalid", dvalid, 1'b1);
    chk("drdata", drdata, 16'h9234);
    chk("x_addr", x_addr, 16'h5892);
    chk("y_active", y_active, 1'b1);
    chk("y_addr", y_addr, 16'h9234);
    dual_mac = 1'b0;
    bitrev = 1'b0;
    dwrite = 1'b0;
    tbl_req = 1'b1;
    tbl_page = 8'h12;
    tick();
    tbl_req = 1'b0;
    chk("prog_addr", prog_addr, 23'h129234);
    tick();
    chk("tbl_rdata", tbl_rdata, 24'h6E9234);
    // Stack pointer value 0x0800 becomes the X operand
    addr_reg = SP_IDX;
    tick();
    mac_go = 1'b1;
    dwdata = 16'h0003;
    tick();
    chk("accumulator_one", acc1, 40'h0000001800);
    acc_sel = 1'b1;
    dwdata = 16'hFFFF;
    tick();
    chk("accumulator_two", acc2, 40'hFFFFFFF800);
    mac_go = 1'b0;
    acc_sel = 1'b0;
    shift_left = 1'b1;
    shift_amt = 5'h04;
    tick();
    chk("accumulator_one", acc1, 40'h0000018000);
    shift_left = 1'b0;
    shift_amt = 5'h11;
    tick();
    chk("accumulator_one", acc1, 40'h0000000001);
    shift_amt = 5'h00;
    modulo_en = 1'b1;
    mod_start = 16'h0800;
    mod_end = 16'h0802;
    tick();
    chk("x_addr", x_addr, 16'h0802);
    tick();
    chk("x_addr", x_addr, 16'h0800);
    modulo_en = 1'b0;
    for (i = 0; i < 8; i++)
      exc(8'h01 << i, -1, -1, 3'h0, 3'h0, i[5:0], 4'hF - i[3:0]);
    exc('0, 5, 9, 3'h3, 3'h3, 6'd13, 4'h3);
    exc('0, 5, 9, 3'h3, 3'h7, 6'd17, 4'h7);
    exc('0, 0, -1, 3'h1, 3'h0, 6'd8, 4'h1);
    exc(8'h08, 53, -1, 3'h7, 3'h0, 6'd3, 4'hC);
    chk("stack_pointer_bit0", stack_pointer_reg[0], 1'b0);
    stop_test();
  end
  initial
  begin
    #50000;
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire

// [dv/cpm_prog_mem_model.sv]
// Purpose: Program memory seen from the core's fetch port
// Assumes: Read data is looked at in the cycle the address is shown
// Notes:   Off cycles show the inverse of the last word, not a held value
`timescale 1ns/1ps
`default_nettype none
module cpm_prog_mem_model
  import cpm_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Fetch port
  input  wire logic [PC_W-1:0]   prog_addr,
  input  wire logic              prog_rd,
  output logic      [INSN_W-1:0] prog_rdata
);
  logic [INSN_W-1:0] last_q;
  assign prog_rdata = prog_rd ? {prog_addr[7:0] ^ 8'h5A, prog_addr[15:0]}
                              : ~last_q;
  always_ff @(posedge clk_sys)
  begin
    last_q <= prog_rdata;
  end
endmodule
`default_nettype wire

// [hw/cpm_core.sv]
// Purpose: Core programmer's model: PC, fetch, data spaces, exceptions
// Assumes: Synchronous memories answer one cycle after request
// Notes:   Arithmetic datapath is dimensional, not a full engine
`timescale 1ns/1ps
`default_nettype none
module cpm_core
  import cpm_pkg::*;
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst,
  // Sequencing control
  input  wire logic                step,
  input  wire logic                jump,
  input  wire logic [PC_W-1:0]     jump_target,
  input  wire logic                loop_start,
  input  wire logic                loop_end,
  input  wire logic [PC_W-1:0]     loop_begin_in,
  input  wire logic [PC_W-1:0]     loop_finish_in,
  input  wire logic [13:0]         loop_count_in,
  input  wire logic                shadow_save,
  input  wire logic                shadow_restore,
  // Program memory
  output logic      [PC_W-1:0]     prog_addr,
  output logic                     prog_rd,
  input  wire logic [INSN_W-1:0]   prog_rdata,
  output logic      [INSN_W-1:0]   insn_word,
  // Data access request
  input  wire logic                dreq,
  input  wire logic                dwrite,
  input  wire logic                dbyte,
  input  wire logic                dual_mac,
  input  wire logic                bitrev,
  input  wire logic                modulo_en,
  input  wire logic [DADDR_W-1:0]  mod_start,
  input  wire logic [DADDR_W-1:0]  mod_end,
  input  wire logic [WIDX_W-1:0]   addr_reg,
  input  wire logic [DADDR_W-1:0]  dwdata,
  input  wire logic                page_we,
  input  wire logic [PAGE_W-1:0]   page_wdata,
  input  wire logic                tbl_req,
  input  wire logic [7:0]          tbl_page,
  // Data answers
  output logic      [DADDR_W-1:0]  x_addr,
  output logic      [DADDR_W-1:0]  y_addr,
  output logic                     y_active,
  output logic                     dvalid,
  output logic      [15:0]         drdata,
  output logic      [INSN_W-1:0]   tbl_rdata,
  output logic      [PAGE_W-1:0]   program_window_page,
  // Datapath
  input  wire logic                mac_go,
  input  wire logic                acc_sel,
  input  wire logic [4:0]          shift_amt,
  input  wire logic                shift_left,
  output logic      [ACC_W-1:0]    accumulator_one,
  output logic      [ACC_W-1:0]    accumulator_two,
  // Exceptions
  input  wire logic [TRAP_N-1:0]   trap_req,
  input  wire logic [IRQ_N-1:0]    irq_req,
  input  wire logic [IRQ_N*3-1:0]  irq_pri,
  output logic                     exc_take,
  output logic      [5:0]          exc_vector,
  output logic      [PRI_W-1:0]    exc_level,
  output logic      [15:0]         status_word,
  output logic      [15:0]         stack_pointer_reg
);
  ////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [PC_W-1:0]    pc;
    logic [INSN_W-1:0]  insn;
    logic               prd;
    logic [PC_W-1:0]    paddr;
    logic [PAGE_W-1:0]  page;
    logic               win_wait;
    logic               tbl_wait;
    logic               dval;
    logic [15:0]        rdat;
    logic [INSN_W-1:0]  trd;
    logic [DADDR_W-1:0] xa;
    logic [DADDR_W-1:0] ya;
    logic               yact;
    logic [PC_W-1:0]    lbeg;
    logic [PC_W-1:0]    lfin;
    logic [13:0]        lcnt;
    logic [PC_W-1:0]    lbeg_sh;
    logic [PC_W-1:0]    lfin_sh;
    logic [13:0]        lcnt_sh;
    logic [15:0]        sw;
    logic [15:0]        sw_sh;
    logic [ACC_W-1:0]   acc1;
    logic [ACC_W-1:0]   acc2;
    logic               exc;
    logic [5:0]         vec;
    logic [PRI_W-1:0]   lvl;
    logic [15:0]        sp;
    logic [1:0]         shidx;
    logic               shbusy;
    logic               shdir;
  } cpm_state_t;

  cpm_state_t s_q;
  cpm_state_t s_d;

  logic             rf_we;
  logic [1:0]       rf_be;
  logic [3:0]       rf_waddr;
  logic [15:0]      rf_wdata;
  logic [3:0]       rf_raddr;
  logic [15:0]      rf_rdata;
  logic [15:0]      w_sh [4];
  logic [15:0]      shw_q [4];

  ////////////////////////////////////////////////////////////////////////
  // Bit-reverse the word index of an address, byte bit kept
  function automatic logic [15:0] bit_rev(input logic [15:0] a);
    logic [15:0] r;
    r = 16'h0000;
    for (int i = 1; i < 16; i++)
      r[i] = a[16-i];
    r[0] = a[0];
    return r;
  endfunction

  // Advance a pointer, wrapping inside a circular buffer
  function automatic logic [15:0] mod_next(input logic [15:0] a,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
    logic [15:0] n;
    n = a + 16'h0002;
    if (a >= hi)
      n = lo;
    return n;
  endfunction

  // Barrel shift by up to sixteen places either way
  function automatic logic [ACC_W-1:0] bshift(input logic [ACC_W-1:0] v,
                                              input logic [4:0] n,
                                              input logic left);
    logic [4:0] k;
    k = (n > 5'h10) ? 5'h10 : n;
    return left ? (v << k) : ACC_W'($signed(v) >>> k);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Exception arbitration
  logic [PRI_W-1:0] best_lvl;
  logic [5:0]       best_vec;
  logic             best_any;
  always_comb
  begin
    best_lvl = 4'h0;
    best_vec = 6'h00;
    best_any = 1'b0;
    for (int i = IRQ_N - 1; i >= 0; i--)
      if (irq_req[i] && irq_pri[i*3 +: 3] >= IRQ_PRI_MIN
          && {1'b0, irq_pri[i*3 +: 3]} >= best_lvl)
      begin
        best_lvl = {1'b0, irq_pri[i*3 +: 3]};
        best_vec = 6'(TRAP_N + i);
        best_any = 1'b1;
      end
    for (int t = TRAP_N - 1; t >= 0; t--)
      if (trap_req[t])
      begin
        best_lvl = TRAP_PRI_MIN + 4'(TRAP_N - 1 - t);
        best_vec = 6'(t);
        best_any = 1'b1;
      end
  end

  ////////////////////////////////////////////////////////////////////////
  logic [15:0] ea;
  logic [15:0] ea_fin;
  always_comb
  begin
    s_d = s_q;
    rf_we = 1'b0;
    rf_be = 2'b00;
    rf_waddr = addr_reg;
    rf_wdata = dwdata;
    rf_raddr = addr_reg;
    ea = rf_rdata;
    ea_fin = ea;
    s_d.dval = 1'b0;
    s_d.exc = 1'b0;
    if (step)
    begin
      s_d.insn = prog_rdata;
      s_d.pc = jump ? {1'b0, jump_target[PC_W-2:1], 1'b0}
                    : {1'b0, s_q.pc[PC_W-2:0] + 22'h000002};
    end
    // Fetch port shows the word at PC unless a window or table read sets the address; a step then takes that word
    s_d.paddr = s_d.pc;
    s_d.prd = 1'b1;
    if (page_we)
      s_d.page = page_wdata;
    if (bitrev && dwrite)
      ea_fin = bit_rev(ea);
    if (modulo_en)
      s_d.xa = mod_next(s_q.xa, mod_start, mod_end);
    s_d.xa = modulo_en ? s_d.xa : ea_fin;
    s_d.yact = dual_mac && ea >= Y_BOUNDARY;
    if (dual_mac)
      s_d.ya = modulo_en ? mod_next(s_q.ya, mod_start, mod_end)
                         : rf_rdata;
    if (dreq && !s_q.win_wait)
    begin
      if (ea_fin >= PSV_BASE && !dwrite)
      begin
        s_d.win_wait = 1'b1;
        s_d.paddr = {s_q.page, ea_fin[14:0]};
        s_d.prd = 1'b1;
      end
      else
      begin
        s_d.dval = 1'b1;
        rf_we = dwrite;
        rf_be = dbyte ? {ea_fin[0], ~ea_fin[0]} : 2'b11;
        rf_wdata = dbyte ? {dwdata[7:0], dwdata[7:0]} : dwdata;
        s_d.rdat = rf_rdata;
      end
    end
    else if (s_q.win_wait)
    begin
      s_d.win_wait = 1'b0;
      s_d.dval = 1'b1;
      s_d.rdat = prog_rdata[15:0];
    end
    // table full 24 bits
    // Word comes back one cycle after the address, like a window read
    if (s_q.tbl_wait)
      s_d.trd = prog_rdata;
    s_d.tbl_wait = tbl_req;
    if (tbl_req)
    begin
      s_d.paddr = {tbl_page[6:0], ea[15:1], 1'b0};
      s_d.prd = 1'b1;
    end
    if (loop_start)
    begin
      s_d.lbeg_sh = s_q.lbeg;
      s_d.lfin_sh = s_q.lfin;
      s_d.lcnt_sh = s_q.lcnt;
      s_d.lbeg = loop_begin_in;
      s_d.lfin = loop_finish_in;
      s_d.lcnt = loop_count_in;
    end
    else if (loop_end)
    begin
      s_d.lbeg = s_q.lbeg_sh;
      s_d.lfin = s_q.lfin_sh;
      s_d.lcnt = s_q.lcnt_sh;
    end
    else if (step && s_q.lcnt != 14'h0000 && s_q.pc == s_q.lfin)
      s_d.lcnt = s_q.lcnt - 14'h0001;
    if (shadow_save)
      s_d.sw_sh = s_q.sw & SHADOW_FLAGS;
    if (shadow_restore)
    begin
      s_d.sw = (s_q.sw & ~SHADOW_FLAGS) | (s_q.sw_sh & SHADOW_FLAGS);
      s_d.shbusy = 1'b1;
      s_d.shidx = 2'h0;
    end
    else if (s_q.shbusy)
    begin
      rf_we = 1'b1;
      rf_be = 2'b11;
      rf_waddr = {2'b00, s_q.shidx};
      rf_wdata = shw_q[s_q.shidx];
      s_d.shidx = s_q.shidx + 2'h1;
      s_d.shbusy = s_q.shidx != 2'h3;
    end
    if (mac_go)
    begin
      if (acc_sel)
        s_d.acc2 = s_q.acc2 + ACC_W'($signed({ea[15], ea})
                                     * $signed({dwdata[15], dwdata}));
      else
        s_d.acc1 = s_q.acc1 + ACC_W'($signed({ea[15], ea})
                                     * $signed({dwdata[15], dwdata}));
    end
    else if (shift_amt != 5'h00)
    begin
      if (acc_sel)
        s_d.acc2 = bshift(s_q.acc2, shift_amt, shift_left);
      else
        s_d.acc1 = bshift(s_q.acc1, shift_amt, shift_left);
    end
    if (best_any)
    begin
      s_d.exc = 1'b1;
      s_d.vec = best_vec;
      s_d.lvl = best_lvl;
      s_d.sp = s_q.sp + 16'h0004;
    end
    s_d.sp[0] = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.pc <= PC_RESET;
      s_q.page <= PAGE_RESET;
      s_q.sp <= SP_RESET;
      s_q.paddr <= PC_RESET;
      s_q.prd <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // W0-W3 shadow copies, captured on save
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      for (int i = 0; i < 4; i++)
        shw_q[i] <= 16'h0000;
    else if (shadow_save)
      for (int i = 0; i < 4; i++)
        shw_q[i] <= w_sh[i];
  end
  // Live W0-W3 track writes seen by the array
  always_ff @(posedge clk_sys)
  begin
    if (rst)
      for (int i = 0; i < 4; i++)
        w_sh[i] <= 16'h0000;
    else if (rf_we && rf_waddr[3:2] == 2'b00)
    begin
      // Byte writes must reach the copy too, or a save takes stale data
      if (rf_be[0])
        w_sh[rf_waddr[1:0]][7:0] <= rf_wdata[7:0];
      if (rf_be[1])
        w_sh[rf_waddr[1:0]][15:8] <= rf_wdata[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working register array
  cpm_wreg_mem u_wreg (
    .clk_sys (clk_sys),
    .rst     (rst),
    .we      (rf_we),
    .be      (rf_be),
    .waddr   (rf_waddr),
    .wdata   (rf_wdata),
    .raddr   (rf_raddr),
    .rdata   (rf_rdata)
  );

  assign prog_addr           = s_q.paddr;
  assign prog_rd             = s_q.prd;
  assign insn_word           = s_q.insn;
  assign x_addr              = s_q.xa;
  assign y_addr              = s_q.ya;
  assign y_active            = s_q.yact;
  assign dvalid              = s_q.dval;
  assign drdata              = s_q.rdat;
  assign tbl_rdata           = s_q.trd;
  assign program_window_page = s_q.page;
  assign accumulator_one     = s_q.acc1;
  assign accumulator_two     = s_q.acc2;
  assign exc_take            = s_q.exc;
  assign exc_vector          = s_q.vec;
  assign exc_level           = s_q.lvl;
  assign status_word         = s_q.sw;
  assign stack_pointer_reg   = s_q.sp;
endmodule
`default_nettype wire

// [hw/cpm_pkg.sv]
// Purpose: Shared constants for the core programmer's model block
// Assumes: One instruction clock, synchronous active-high reset
// Notes:   Widths, reset values and priority ranges of the core state
package cpm_pkg;
  localparam int PC_W        = 23;
  localparam int INSN_W      = 24;
  localparam int WREG_W      = 16;
  localparam int WREG_N      = 16;
  localparam int WIDX_W      = 4;
  localparam int DADDR_W     = 16;
  localparam int PAGE_W      = 8;
  localparam int ACC_W       = 40;
  localparam int MUL_IN_W    = 17;
  localparam int SHIFT_MAX   = 16;
  localparam int VEC_N       = 62;
  localparam int TRAP_N      = 8;
  localparam int IRQ_N       = 54;
  localparam int PRI_W       = 4;
  localparam logic [3:0]  SP_IDX       = 4'hF;
  localparam logic [15:0] SP_RESET     = 16'h0800;
  localparam logic [15:0] PSV_BASE     = 16'h8000;
  localparam logic [15:0] Y_BOUNDARY   = 16'h1800;
  localparam logic [22:0] PC_RESET     = 23'h000000;
  localparam logic [7:0]  PAGE_RESET   = 8'h00;
  localparam logic [2:0]  IRQ_PRI_MIN  = 3'h1;
  localparam logic [3:0]  TRAP_PRI_MIN = 4'h8;
  // Status word flag positions
  localparam int SW_C  = 0;
  localparam int SW_Z  = 1;
  localparam int SW_OV = 2;
  localparam int SW_N  = 3;
  localparam int SW_DC = 8;
  localparam logic [15:0] SHADOW_FLAGS = 16'h010F;
  typedef enum logic [1:0] {CPM_ACC_NONE, CPM_ACC_DATA, CPM_ACC_WIN}
    cpm_dkind_t;
endpackage

// [hw/cpm_wreg_mem.sv]
// Purpose: Working register array, sixteen 16-bit words
// Assumes: Byte enables for byte-wide and low-byte operations
// Notes:   Read data registered; stack pointer bit 0 forced clear
`timescale 1ns/1ps
`default_nettype none
module cpm_wreg_mem
  import cpm_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst,
  // Write port
  input  wire logic              we,
  input  wire logic [1:0]        be,
  input  wire logic [WIDX_W-1:0] waddr,
  input  wire logic [15:0]       wdata,
  // Read port
  input  wire logic [WIDX_W-1:0] raddr,
  output logic      [15:0]       rdata
);
  logic [15:0] mem [WREG_N];

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      for (int i = 0; i < WREG_N; i++)
        mem[i] <= (4'(i) == SP_IDX) ? SP_RESET : 16'h0000;
      rdata <= 16'h0000;
    end
    else
    begin
      if (we && be[0])
        mem[waddr][7:0] <= (waddr == SP_IDX) ? {wdata[7:1], 1'b0}
                                              : wdata[7:0];
      if (we && be[1])
        mem[waddr][15:8] <= wdata[15:8];
      rdata <= mem[raddr];
    end
  end
endmodule
`default_nettype wire
